// File: rtl/pbh_pkg.sv
// Purpose: shared constants and types of the parallel host bus controller
// Assumes: 125 MHz system clock, 8-bit data on the external bus
// Notes  : Function
// Function
// - strobe style: write, read, fetch on pins
// - direction-enable style: direction pin zero, enable one
// - single read strobe host: fetch on pin one
// - two read strobes: read pin one, fetch two
// - non-page mode: latch strobe every cycle, except burst-mode fetch hits, which skip it
// - burst 8-bit: A11-A4 multiplexed, A3-A0 separate
package pbh_pkg;

  // ------------------------------------------------------------
  // bus configuration
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PBH_MUX,
    PBH_PAGE,
    PBH_BURST,
    PBH_NONMUX
  } pbh_mode_t;

  typedef enum logic {
    PBH_STROBES,
    PBH_DIR_ENA
  } pbh_style_t;

  typedef enum logic [1:0] {
    PBH_RD,
    PBH_WR,
    PBH_FETCH
  } pbh_kind_t;

  // ------------------------------------------------------------
  // widths and field positions
  // ------------------------------------------------------------
  localparam int ADDR_W    = 20;
  localparam int DATA_W    = 8;
  localparam int PORT_W    = 16;
  localparam int EXT_W     = 4;
  localparam int LOW_W     = 4;
  localparam int EXT_LSB   = 16;
  localparam int HI_LSB    = 8;
  localparam int BURST_LSB = 4;
  localparam int BHI_LSB   = 12;
  localparam int SYNC_W    = PORT_W + DATA_W;

  // ------------------------------------------------------------
  // timing, in ns and in cycles (rounded up)
  // ------------------------------------------------------------
  localparam int CLK_NS     = 8;
  localparam int T_ADDR_NS  = 24;
  localparam int T_LATCH_NS = 16;
  localparam int T_STB_NS   = 120;
  localparam int T_HOLD_NS  = 16;
  localparam int SYNC_CYC   = 3;
  localparam int ADDR_CYC   = (T_ADDR_NS + CLK_NS - 1) / CLK_NS;
  localparam int LATCH_CYC  = (T_LATCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB_CYC    = (T_STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 8;

  // idle levels of the pins
  localparam logic STB_IDLE = 1'h1;
  localparam logic ALE_IDLE = 1'h0;

endpackage : pbh_pkg

// File: rtl/pbh_sync_if.sv
`timescale 1ns/1ps
// Purpose: carries raw pin levels to the synchroniser and clean levels back
// Assumes: one clock domain on the controller side
// Notes  : width covers shared port and separate data port
interface pbh_sync_if #(
  parameter int W = 24
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport user (output raw, input clean);
  modport sync (input raw, output clean);
endinterface : pbh_sync_if

// File: rtl/pbh_pin_sync.sv
`timescale 1ns/1ps
// Purpose: three-stage synchroniser for bus input pins
// Assumes: inputs are asynchronous to clk_sys_i
// Notes  : a change is taken once stages two and three agree
module pbh_pin_sync #(
  parameter int W = 24
) (
  // clock, enable, reset
  input  wire logic clk_sys_i,
  input  wire logic ce_i,
  input  wire logic srst_i,
  // pin levels
  pbh_sync_if.sync  pins
);

  // ------------------------------------------------------------
  // per-bit stages
  // ------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic held;
      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          s1   <= 1'h0;
          s2   <= 1'h0;
          s3   <= 1'h0;
          held <= 1'h0;
        end else if (ce_i) begin
          s1 <= pins.raw[b];
          s2 <= s1;
          s3 <= s2;
          // a one-cycle glitch never reaches the user
          if (s2 == s3) begin
            held <= s3;
          end
        end
      end
      assign pins.clean[b] = held;
    end
  endgenerate

endmodule : pbh_pin_sync

// File: rtl/pbh_host.sv
`timescale 1ns/1ps
// Purpose: host-side master for the device's parallel microcontroller bus
// Assumes: bus mode and strobe style are fixed by parameters
// Notes  : all pins come from flip-flops; read data pass the synchroniser
module pbh_host #(
  parameter pbh_pkg::pbh_mode_t  MODE         = pbh_pkg::PBH_MUX,
  parameter pbh_pkg::pbh_style_t STYLE        = pbh_pkg::PBH_STROBES,
  parameter int                  READ_STROBES = 2,
  parameter bit                  NONMUX_ALE   = 1'b1,
  parameter int                  ADDR_CYC     = pbh_pkg::ADDR_CYC,
  parameter int                  LATCH_CYC    = pbh_pkg::LATCH_CYC,
  parameter int                  STB_CYC      = pbh_pkg::STB_CYC,
  parameter int                  HOLD_CYC     = pbh_pkg::HOLD_CYC
) (
  // clock, enable, reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         ce_i,
  input  wire logic                         srst_i,
  // user request
  input  wire logic                         req_valid_i,
  input  wire pbh_pkg::pbh_kind_t           req_kind_i,
  input  wire logic [pbh_pkg::ADDR_W-1:0]   req_addr_i,
  input  wire logic [pbh_pkg::DATA_W-1:0]   req_wdata_i,
  output logic                              req_ready_o,
  // user answer
  output logic                              rsp_valid_o,
  output logic [pbh_pkg::DATA_W-1:0]        rsp_rdata_o,
  // control pins
  output logic                              control_pin_zero_o,
  output logic                              control_pin_one_o,
  output logic                              control_pin_two_o,
  output logic                              address_latch_strobe_o,
  // shared address/data port, per-byte enables
  input  wire logic [pbh_pkg::PORT_W-1:0]   shared_addr_data_port_i,
  output logic [pbh_pkg::PORT_W-1:0]        shared_addr_data_port_o,
  output logic [1:0]                        shared_addr_data_port_oe_o,
  // separate data port of the non-multiplexed bus
  input  wire logic [pbh_pkg::DATA_W-1:0]   data_port_i,
  output logic [pbh_pkg::DATA_W-1:0]        data_port_o,
  output logic                              data_port_oe_o,
  // extra address pins
  output logic [pbh_pkg::EXT_W-1:0]         upper_addr_o,
  output logic [pbh_pkg::LOW_W-1:0]         low_addr_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_LATCH,
    ST_STROBE,
    ST_HOLD
  } pbh_state_t;

  localparam logic [pbh_pkg::CNT_W-1:0] ADDR_N  = pbh_pkg::CNT_W'(ADDR_CYC - 1);
  localparam logic [pbh_pkg::CNT_W-1:0] LATCH_N = pbh_pkg::CNT_W'(LATCH_CYC - 1);
  // read strobe stays up long enough for the synchroniser to settle
  localparam logic [pbh_pkg::CNT_W-1:0] STB_N   =
    pbh_pkg::CNT_W'(STB_CYC + pbh_pkg::SYNC_CYC - 1);
  localparam logic [pbh_pkg::CNT_W-1:0] HOLD_N  = pbh_pkg::CNT_W'(HOLD_CYC - 1);

  pbh_state_t                     state;
  pbh_state_t                     next_state;
  logic [pbh_pkg::CNT_W-1:0]      cnt;
  pbh_pkg::pbh_kind_t             kind;
  logic [pbh_pkg::ADDR_W-1:0]     addr;
  logic [pbh_pkg::DATA_W-1:0]     wdata;
  logic [pbh_pkg::ADDR_W-1:0]     last_addr;
  logic                           last_valid;
  logic                           hit;
  logic                           need_ale;
  logic                           is_rd;
  logic                           cnt_done;

  pbh_sync_if #(.W(pbh_pkg::SYNC_W)) sync_bus ();

  assign sync_bus.raw = {data_port_i, shared_addr_data_port_i};

  pbh_pin_sync #(.W(pbh_pkg::SYNC_W)) u_sync (
    .clk_sys_i (clk_sys_i),
    .ce_i      (ce_i),
    .srst_i    (srst_i),
    .pins      (sync_bus.sync)
  );

  // ------------------------------------------------------------
  // page / burst hit detection
  // ------------------------------------------------------------
  always_comb begin
    hit = 1'b0;
    if (MODE == pbh_pkg::PBH_PAGE) begin
      hit = last_valid && (last_addr[pbh_pkg::ADDR_W-1:pbh_pkg::HI_LSB] ==
            req_addr_i[pbh_pkg::ADDR_W-1:pbh_pkg::HI_LSB]);
    end else if (MODE == pbh_pkg::PBH_BURST) begin
      hit = last_valid && (req_kind_i == pbh_pkg::PBH_FETCH) &&
            (last_addr[pbh_pkg::ADDR_W-1:pbh_pkg::BURST_LSB] ==
             req_addr_i[pbh_pkg::ADDR_W-1:pbh_pkg::BURST_LSB]);
    end
  end

  // plain multiplexed cycles always strobe the latch; page hits and burst fetch hits skip it
  assign need_ale = (MODE == pbh_pkg::PBH_NONMUX) ? NONMUX_ALE : !hit;
  assign is_rd    = (kind != pbh_pkg::PBH_WR);
  assign cnt_done = (state == ST_ADDR   && cnt == ADDR_N)  ||
                    (state == ST_LATCH  && cnt == LATCH_N) ||
                    (state == ST_STROBE && cnt == STB_N)   ||
                    (state == ST_HOLD   && cnt == HOLD_N);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (req_valid_i) next_state = need_ale ? ST_ADDR : ST_LATCH;
      ST_ADDR:   if (cnt_done) next_state = ST_LATCH;
      ST_LATCH:  if (cnt_done) next_state = ST_STROBE;
      ST_STROBE: if (cnt_done) next_state = ST_HOLD;
      ST_HOLD:   if (cnt_done) next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else if (ce_i) begin
      state <= next_state;
      cnt   <= (next_state != state) ? '0 : cnt + 1'b1;
    end
  end

  // request capture and remembered latched address
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      kind       <= pbh_pkg::PBH_RD;
      addr       <= '0;
      wdata      <= '0;
      last_addr  <= '0;
      last_valid <= 1'b0;
    end else if (ce_i && state == ST_IDLE && req_valid_i) begin
      kind       <= req_kind_i;
      addr       <= req_addr_i;
      wdata      <= req_wdata_i;
      last_addr  <= req_addr_i;
      last_valid <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // user handshake
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else if (ce_i) begin
      req_ready_o <= (next_state == ST_IDLE);
      rsp_valid_o <= (state == ST_HOLD) && cnt_done;
      if (state == ST_STROBE && cnt_done && is_rd) begin
        if (MODE == pbh_pkg::PBH_NONMUX) begin
          rsp_rdata_o <= sync_bus.clean[pbh_pkg::SYNC_W-1:pbh_pkg::PORT_W];
        end else if (MODE == pbh_pkg::PBH_PAGE) begin
          rsp_rdata_o <= sync_bus.clean[pbh_pkg::PORT_W-1:pbh_pkg::HI_LSB];
        end else begin
          rsp_rdata_o <= sync_bus.clean[pbh_pkg::DATA_W-1:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // control pins
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      address_latch_strobe_o <= pbh_pkg::ALE_IDLE;
      control_pin_zero_o     <= pbh_pkg::STB_IDLE;
      control_pin_one_o      <= (STYLE == pbh_pkg::PBH_DIR_ENA) ? 1'b0 : pbh_pkg::STB_IDLE;
      control_pin_two_o      <= pbh_pkg::STB_IDLE;
    end else if (ce_i) begin
      address_latch_strobe_o <= (next_state == ST_ADDR);
      if (STYLE == pbh_pkg::PBH_DIR_ENA) begin
        // direction set ahead of the enable, kept through hold
        if (state == ST_IDLE && req_valid_i) begin
          control_pin_zero_o <= (req_kind_i != pbh_pkg::PBH_WR);
        end
        control_pin_one_o <= (next_state == ST_STROBE);
        control_pin_two_o <= pbh_pkg::STB_IDLE;
      end else begin
        control_pin_zero_o <= !((next_state == ST_STROBE) && kind == pbh_pkg::PBH_WR);
        if (READ_STROBES == 1) begin
          control_pin_one_o <= !((next_state == ST_STROBE) && is_rd);
          control_pin_two_o <= pbh_pkg::STB_IDLE;
        end else begin
          control_pin_one_o <= !((next_state == ST_STROBE) && kind == pbh_pkg::PBH_RD);
          control_pin_two_o <= !((next_state == ST_STROBE) && kind == pbh_pkg::PBH_FETCH);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // address and data pins
  // ------------------------------------------------------------
  logic                       drive_wr;
  logic                       in_cycle;
  logic                       addr_phase;
  logic [pbh_pkg::ADDR_W-1:0] pin_addr;
  // the address must already stand on the pins when the latch strobe rises
  assign pin_addr   = (state == ST_IDLE) ? req_addr_i : addr;
  // address kept one cycle past the falling latch strobe as hold time
  assign addr_phase = (next_state == ST_ADDR) || (state == ST_ADDR);
  assign drive_wr = !is_rd && (next_state == ST_LATCH || next_state == ST_STROBE ||
                               next_state == ST_HOLD) && state != ST_IDLE;
  assign in_cycle = (next_state != ST_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      shared_addr_data_port_o    <= '0;
      shared_addr_data_port_oe_o <= '0;
      data_port_o                <= '0;
      data_port_oe_o             <= 1'b0;
      upper_addr_o               <= '0;
      low_addr_o                 <= '0;
    end else if (ce_i && (state != ST_IDLE || in_cycle)) begin
      upper_addr_o <= pin_addr[pbh_pkg::ADDR_W-1:pbh_pkg::EXT_LSB];
      unique case (MODE)
        pbh_pkg::PBH_MUX: begin
          shared_addr_data_port_o[pbh_pkg::PORT_W-1:pbh_pkg::HI_LSB] <=
            pin_addr[pbh_pkg::EXT_LSB-1:pbh_pkg::HI_LSB];
          shared_addr_data_port_oe_o[1] <= in_cycle;
          // low byte: address while latching, then data or released
          shared_addr_data_port_o[pbh_pkg::DATA_W-1:0] <=
            addr_phase ? pin_addr[pbh_pkg::DATA_W-1:0] : wdata;
          shared_addr_data_port_oe_o[0] <= addr_phase || drive_wr;
        end
        pbh_pkg::PBH_PAGE: begin
          // low byte is never multiplexed, so a page hit only moves it
          shared_addr_data_port_o[pbh_pkg::DATA_W-1:0] <=
            pin_addr[pbh_pkg::DATA_W-1:0];
          shared_addr_data_port_oe_o[0] <= in_cycle;
          shared_addr_data_port_o[pbh_pkg::PORT_W-1:pbh_pkg::HI_LSB] <=
            addr_phase ? pin_addr[pbh_pkg::EXT_LSB-1:pbh_pkg::HI_LSB] : wdata;
          shared_addr_data_port_oe_o[1] <= addr_phase || drive_wr;
        end
        pbh_pkg::PBH_BURST: begin
          shared_addr_data_port_o[pbh_pkg::PORT_W-1:pbh_pkg::HI_LSB] <=
            pin_addr[pbh_pkg::ADDR_W-1:pbh_pkg::BHI_LSB];
          shared_addr_data_port_oe_o[1] <= in_cycle;
          shared_addr_data_port_o[pbh_pkg::DATA_W-1:0] <= addr_phase ?
            pin_addr[pbh_pkg::BHI_LSB-1:pbh_pkg::BURST_LSB] : wdata;
          shared_addr_data_port_oe_o[0] <= addr_phase || drive_wr;
          low_addr_o <= pin_addr[pbh_pkg::LOW_W-1:0];
        end
        pbh_pkg::PBH_NONMUX: begin
          shared_addr_data_port_o    <= pin_addr[pbh_pkg::PORT_W-1:0];
          shared_addr_data_port_oe_o <= {2{in_cycle}};
          data_port_o                <= wdata;
          data_port_oe_o             <= drive_wr;
        end
      endcase
    end
  end

endmodule : pbh_host

// File: tb/pbh_host_properties.sv
`timescale 1ns/1ps
// Purpose: port assertions for the host bus master
// Assumes: multiplexed bus, strobe style, fetch strobe on pin two
// Notes  : sees only top-level ports; bound below
module pbh_host_properties (
  input wire logic                      clk_sys_i,
  input wire logic                      srst_i,
  input wire logic                      req_valid_i,
  input wire logic                      req_ready_o,
  input wire logic                      rsp_valid_o,
  input wire logic                      control_pin_zero_o,
  input wire logic                      control_pin_one_o,
  input wire logic                      control_pin_two_o,
  input wire logic                      address_latch_strobe_o,
  input wire logic [1:0]                shared_addr_data_port_oe_o,
  input wire logic [pbh_pkg::EXT_W-1:0] upper_addr_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  a_ale_per_take: assert property (req_valid_i && req_ready_o |=>
    address_latch_strobe_o [*3] ##1 !address_latch_strobe_o) else $error("latch pulse wrong");
  a_addr_both_lanes: assert property (address_latch_strobe_o |->
    shared_addr_data_port_oe_o == 2'h3) else $error("address not on both lanes");
  a_idle_in_latch: assert property (address_latch_strobe_o |-> control_pin_zero_o
    && control_pin_one_o && control_pin_two_o) else $error("strobe during latch");
  a_read_lane_free: assert property (!control_pin_one_o || !control_pin_two_o |->
    !shared_addr_data_port_oe_o[0]) else $error("low lane driven during read");
  a_write_drives: assert property (!control_pin_zero_o |-> shared_addr_data_port_oe_o[0]
    && control_pin_one_o && control_pin_two_o) else $error("write strobe misuse");
  a_fetch_alone: assert property (!control_pin_two_o |-> control_pin_one_o)
    else $error("fetch and read together");
  a_rsp_latency: assert property (req_valid_i && req_ready_o |-> ##26 rsp_valid_o)
    else $error("answer late or early");
  a_busy_taken: assert property (req_valid_i && req_ready_o |=> !req_ready_o
    until rsp_valid_o) else $error("ready during transfer");
  a_upper_steady: assert property ($fell(control_pin_one_o) |->
    $stable(upper_addr_o) [*8]) else $error("upper address moved");
endmodule : pbh_host_properties

bind pbh_host pbh_host_properties pbh_host_properties_i (
  .clk_sys_i, .srst_i, .req_valid_i, .req_ready_o, .rsp_valid_o, .control_pin_zero_o,
  .control_pin_one_o, .control_pin_two_o, .address_latch_strobe_o,
  .shared_addr_data_port_oe_o, .upper_addr_o
);

// File: tb/pbh_dev_model.sv
`timescale 1ns/1ps
// Purpose: behavioural memory device on the multiplexed bus
// Assumes: strobe style with fetch strobe on pin two
// Notes  : unwritten bytes return a value folded from the address
module pbh_dev_model (
  input  wire logic        ale_i,
  input  wire logic        wr_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        fetch_n_i,
  input  wire logic        slow_i,
  input  wire logic [3:0]  upper_i,
  input  wire logic [15:0] bus_i,
  output logic [7:0]       dev_o,
  output logic             dev_oe_o,
  output logic [19:0]      lat_addr_o
);
  logic [7:0] mem [logic [19:0]];

  function automatic logic [7:0] peek(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
  endfunction : peek

  initial begin
    dev_o = 8'h00;
    lat_addr_o = 20'h00000;
  end
  always @(negedge ale_i) lat_addr_o = {upper_i, bus_i};
  assign dev_oe_o = !rd_n_i || !fetch_n_i;
  // wrong byte shown until the access time has run out
  always @(negedge rd_n_i or negedge fetch_n_i) begin
    dev_o = ~peek(lat_addr_o);
    #(slow_i ? 90 : 8);
    dev_o = peek(lat_addr_o);
  end
  always @(posedge wr_n_i) mem[lat_addr_o] = bus_i[7:0];
endmodule : pbh_dev_model

// File: tb/test_mcu_parallel_bus_interface.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for the host bus master
// Assumes: multiplexed bus, strobe style, default timing
// Notes  : released lanes toggle every cycle so stale data cannot pass
module test_mcu_parallel_bus_interface;
  logic               clk_sys_i   = 1'b0;
  logic               ce_i        = 1'b1;
  logic               srst_i      = 1'b1;
  logic               req_valid_i = 1'b0;
  pbh_pkg::pbh_kind_t req_kind_i  = pbh_pkg::PBH_RD;
  logic [19:0]        req_addr_i  = 20'h00000;
  logic [7:0]         req_wdata_i = 8'h00;
  logic [7:0]         data_port_i = 8'h00;
  logic               slow        = 1'b0;
  logic [15:0]        bus_q       = 16'h0000;
  logic [15:0]        shared_addr_data_port_i, shared_addr_data_port_o;
  logic [1:0]         shared_addr_data_port_oe_o;
  logic               req_ready_o, rsp_valid_o, control_pin_zero_o, control_pin_one_o;
  logic               control_pin_two_o, address_latch_strobe_o, data_port_oe_o;
  logic [7:0]         rsp_rdata_o, data_port_o, dev_o;
  logic [3:0]         upper_addr_o, low_addr_o;
  logic               dev_oe, saw_rd, saw_wr, saw_fe;
  logic [19:0]        lat_addr;
  logic [7:0]         mem [logic [19:0]];
  int                 failures    = 0;
  int                 checks_done = 0;
  bit                 timed_out   = 1'b0;

  // bus style fixed at elaboration, never switched while running
  pbh_host #(.MODE(pbh_pkg::PBH_MUX), .STYLE(pbh_pkg::PBH_STROBES)) pbh_host_i (
    .clk_sys_i, .ce_i, .srst_i, .req_valid_i, .req_kind_i, .req_addr_i, .req_wdata_i,
    .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .control_pin_zero_o, .control_pin_one_o,
    .control_pin_two_o, .address_latch_strobe_o, .shared_addr_data_port_i,
    .shared_addr_data_port_o, .shared_addr_data_port_oe_o, .data_port_i, .data_port_o,
    .data_port_oe_o, .upper_addr_o, .low_addr_o
  );
  pbh_dev_model pbh_dev_model_i (
    .ale_i(address_latch_strobe_o), .wr_n_i(control_pin_zero_o), .rd_n_i(control_pin_one_o),
    .fetch_n_i(control_pin_two_o), .slow_i(slow), .upper_i(upper_addr_o),
    .bus_i(shared_addr_data_port_i), .dev_o(dev_o), .dev_oe_o(dev_oe), .lat_addr_o(lat_addr)
  );

  always #4 clk_sys_i = ~clk_sys_i;

  always_comb begin
    shared_addr_data_port_i = ~bus_q;
    if (dev_oe) shared_addr_data_port_i[7:0] = dev_o;
    if (shared_addr_data_port_oe_o[0]) shared_addr_data_port_i[7:0] = shared_addr_data_port_o[7:0];
    if (shared_addr_data_port_oe_o[1]) shared_addr_data_port_i[15:8] = shared_addr_data_port_o[15:8];
  end

  always @(posedge clk_sys_i) begin
    bus_q <= shared_addr_data_port_i;
    if (!control_pin_zero_o) saw_wr <= 1'b1;
    if (!control_pin_one_o) saw_rd <= 1'b1;
    if (!control_pin_two_o) saw_fe <= 1'b1;
  end

  function automatic logic [7:0] exp_byte(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
  endfunction : exp_byte

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic do_reset(input int cyc);
    srst_i <= 1'b1;
    repeat (cyc) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    // look once the first edge after release has settled
    @(negedge clk_sys_i);
    chk(20'({data_port_o, low_addr_o, data_port_oe_o, control_pin_zero_o, control_pin_one_o,
        control_pin_two_o, address_latch_strobe_o, shared_addr_data_port_oe_o, req_ready_o}),
        20'h00071, "idle pins");
    @(posedge clk_sys_i);
  endtask : do_reset

  task automatic xfer(input pbh_pkg::pbh_kind_t k, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    slow <= 1'($urandom);
    data_port_i <= 8'($urandom);
    req_kind_i <= k;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_valid_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 100);
    req_valid_i <= 1'b0;
    saw_rd = 1'b0;
    saw_wr = 1'b0;
    saw_fe = 1'b0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      timed_out = 1'b1;
    end else begin
      chk(lat_addr, a, "latched address");
      chk(20'({saw_wr, saw_rd, saw_fe}), 20'({k == pbh_pkg::PBH_WR, k == pbh_pkg::PBH_RD,
          k == pbh_pkg::PBH_FETCH}), "strobe pin");
      if (k == pbh_pkg::PBH_WR) mem[a] = d;
      else chk(20'(rsp_rdata_o), 20'(exp_byte(a)), "read data");
    end
  endtask : xfer

  // back-to-back random traffic over a few addresses, reset once in mid-run
  initial begin
    logic [19:0] a;
    pbh_pkg::pbh_kind_t k;
    void'($urandom(14023));
    do_reset(12);
    for (int i = 0; i < 60 && !timed_out; i++) begin
      a = {2'($urandom), 2'h3, 8'hA5, 6'h00, 2'($urandom)};
      k = pbh_pkg::pbh_kind_t'($urandom_range(2, 0));
      if (i == 30) do_reset(2);
      xfer(k, a, 8'($urandom));
      if (k == pbh_pkg::PBH_WR && !timed_out) xfer(pbh_pkg::PBH_FETCH, a, 8'h00);
    end
    conclude();
  end
endmodule : test_mcu_parallel_bus_interface
